// >>> hw/lsf_gain_dec.sv
// Registered decode of analog and digital gain codes into multipliers
`timescale 1ns/1ps
`default_nettype none
module lsf_gain_dec (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] again,
	input wire logic [2:0] post_scale_sel,
	output logic [8:0] analog_gain_q,
	output logic [4:0] digital_gain_q
);
	always_ff @(posedge clk) begin
		if (reset) begin
			analog_gain_q <= 9'h001;
		end else begin
			unique case (again)
				3'h0: analog_gain_q <= 9'h001;
				3'h1: analog_gain_q <= 9'h004;
				3'h2: analog_gain_q <= 9'h010;
				3'h3: analog_gain_q <= 9'h080;
				default: analog_gain_q <= 9'h100;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			digital_gain_q <= 5'h01;
		end else if (post_scale_sel[2]) begin
			digital_gain_q <= 5'h10;
		end else begin
			digital_gain_q <= 5'(5'h01 << post_scale_sel[1:0]);
		end
	end
endmodule
`default_nettype wire

// >>> hw/lsf_pkg.sv
// Constants, types and helpers shared by the light sensor flag/config block
package lsf_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_GAIN_INT = 8'h09;
	localparam logic [7:0] ADDR_WAIT_SCALE = 8'h0a;

	localparam int FLAG_AMB_HIGH = 5;
	localparam int FLAG_AMB_LOW = 4;
	localparam int FLAG_IR_HIGH = 3;
	localparam int FLAG_IR_LOW = 2;
	localparam int FLAG_DARK_HIGH = 1;
	localparam int FLAG_DARK_LOW = 0;
	localparam int NUM_FLAGS = 6;

	localparam logic [5:0] FLAGS_RESET = 6'h00;
	localparam logic [3:0] PERIOD_RESET = 4'h8;
	localparam logic [2:0] AGAIN_RESET = 3'h0;
	localparam logic [2:0] POST_SCALE_SEL_RESET = 3'h0;
	localparam logic SUB_RESET = 1'b1;
	localparam logic [3:0] WAIT_RESET = 4'h0;
	localparam int WAIT_SHIFT_BASE = 6;

	////////////////////////////////////////////////////////////////////////////
	// Timing: clock 100 ns, integration unit 0.1 ms, slow clock period 6.1 us
	localparam int CLK_PERIOD_NS = 100;
	localparam int INTEG_UNIT_US = 100;
	localparam int SLOW_PERIOD_NS = 6100;
	localparam int UNIT_CYCLES = INTEG_UNIT_US * 1000 / CLK_PERIOD_NS;
	localparam int SLOW_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 22;

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic unused;
		logic [3:0] period;
		logic [2:0] again;
	} lsf_gain_int_s;

	typedef struct packed {
		logic [2:0] post_scale_sel;
		logic sub_en;
		logic [3:0] wait_sel;
	} lsf_wait_scale_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lsf_req_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INTEG = 2'b01,
		ST_WAIT = 2'b11
	} lsf_state_e;

	// Integration period in 0.1 ms units
	function automatic logic [21:0] integ_units(input logic [3:0] code);
		logic [21:0] u;
		u = 22'h00_3E80;
		unique case (code)
			4'h0: u = 22'h00_0002;
			4'h1: u = 22'h00_0004;
			4'h2: u = 22'h00_0008;
			4'h3: u = 22'h00_0010;
			4'h4: u = 22'h00_001F;
			4'h5: u = 22'h00_003F;
			4'h6: u = 22'h00_007D;
			4'h7: u = 22'h00_00FA;
			4'h8: u = 22'h00_01F4;
			4'h9: u = 22'h00_03E8;
			4'hA: u = 22'h00_07D0;
			4'hB: u = 22'h00_0FA0;
			4'hC: u = 22'h00_1F40;
			4'hD, 4'hE, 4'hF: u = 22'h00_3E80;
		endcase
		return u;
	endfunction

endpackage

// >>> hw/lsf_tick.sv
// Periodic one-cycle tick divider with synchronous restart
`timescale 1ns/1ps
`default_nettype none
module lsf_tick #(
	parameter int DIV = 61
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic restart,
	output logic tick_q
);
	localparam int W = $clog2(DIV + 1);
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (reset || restart) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + W'(1);
			tick_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> hw/lsf_top.sv
// Threshold flag register and measurement configuration with sequencer
`timescale 1ns/1ps
`default_nettype none
module lsf_top (
	input wire logic clk,
	input wire logic reset,
	input wire lsf_pkg::lsf_req_s req,
	input wire logic [5:0] flag_set,
	input wire logic clear_source_sel,
	input wire logic dark_low_read,
	input wire logic reset_cmd,
	input wire logic sync_single_en,
	input wire logic meas_enable,
	output logic [7:0] rdata_q,
	output logic [5:0] flags_q,
	output logic [8:0] analog_gain_q,
	output logic [4:0] digital_gain_q,
	output logic dark_sub_en_q,
	output logic integrating_q,
	output logic meas_start_q,
	output logic meas_done_q,
	output logic meas_abort_q
);

	////////////////////////////////////////////////////////////////////////////
	// Register storage

	lsf_pkg::lsf_gain_int_s gain_int_q;
	lsf_pkg::lsf_wait_scale_s wait_scale_q;
	lsf_pkg::lsf_state_e state_q;
	logic [lsf_pkg::CNT_W-1:0] cnt_q;
	logic [5:0] flag_clr;
	logic flag_clear_evt;
	logic cfg_write;
	logic restart;
	logic unit_tick;
	logic slow_tick;
	logic [lsf_pkg::CNT_W-1:0] integ_limit;
	logic [lsf_pkg::CNT_W-1:0] wait_limit;

	assign cfg_write = req.wr && (req.addr == lsf_pkg::ADDR_GAIN_INT ||
		req.addr == lsf_pkg::ADDR_WAIT_SCALE);
	// Any configuration write while running aborts and restarts
	assign restart = cfg_write && state_q != lsf_pkg::ST_IDLE;

	always_ff @(posedge clk) begin
		if (reset) begin
			gain_int_q.unused <= 1'b0;
			gain_int_q.period <= lsf_pkg::PERIOD_RESET;
			gain_int_q.again <= lsf_pkg::AGAIN_RESET;
		end else if (req.wr && req.addr == lsf_pkg::ADDR_GAIN_INT) begin
			gain_int_q <= lsf_pkg::lsf_gain_int_s'(req.wdata);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wait_scale_q.post_scale_sel <= lsf_pkg::POST_SCALE_SEL_RESET;
			wait_scale_q.sub_en <= lsf_pkg::SUB_RESET;
			wait_scale_q.wait_sel <= lsf_pkg::WAIT_RESET;
		end else if (req.wr && req.addr == lsf_pkg::ADDR_WAIT_SCALE) begin
			wait_scale_q <= lsf_pkg::lsf_wait_scale_s'(req.wdata);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dark_sub_en_q <= lsf_pkg::SUB_RESET;
		end else begin
			dark_sub_en_q <= wait_scale_q.sub_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Threshold event flags

	always_comb begin
		flag_clear_evt = reset_cmd || sync_single_en;
		if (clear_source_sel) begin
			flag_clear_evt = flag_clear_evt || dark_low_read;
		end else begin
			flag_clear_evt = flag_clear_evt ||
				(req.rd && req.addr == lsf_pkg::ADDR_FLAGS);
		end
		flag_clr = flag_clear_evt ? 6'h3F : 6'h00;
	end

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			flags_q <= lsf_pkg::FLAGS_RESET;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				lsf_pkg::ADDR_FLAGS: rdata_q <= {2'b00, flags_q};
				lsf_pkg::ADDR_GAIN_INT: rdata_q <= gain_int_q;
				lsf_pkg::ADDR_WAIT_SCALE: rdata_q <= wait_scale_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Measurement sequencer

	always_comb begin
		integ_limit = lsf_pkg::integ_units(gain_int_q.period);
		wait_limit = lsf_pkg::CNT_W'(1) << (5'(wait_scale_q.wait_sel) +
			5'(lsf_pkg::WAIT_SHIFT_BASE));
	end

	lsf_tick #(
		.DIV(lsf_pkg::UNIT_CYCLES)
	) u_unit_tick (
		.clk(clk),
		.reset(reset),
		.restart(restart || meas_start_q),
		.tick_q(unit_tick)
	);

	lsf_tick #(
		.DIV(lsf_pkg::SLOW_CYCLES)
	) u_slow_tick (
		.clk(clk),
		.reset(reset),
		.restart(restart),
		.tick_q(slow_tick)
	);

	lsf_gain_dec u_gain_dec (
		.clk(clk),
		.reset(reset),
		.again(gain_int_q.again),
		.post_scale_sel(wait_scale_q.post_scale_sel),
		.analog_gain_q(analog_gain_q),
		.digital_gain_q(digital_gain_q)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= lsf_pkg::ST_IDLE;
			cnt_q <= '0;
			meas_start_q <= 1'b0;
			meas_done_q <= 1'b0;
			meas_abort_q <= 1'b0;
		end else begin
			meas_start_q <= 1'b0;
			meas_done_q <= 1'b0;
			meas_abort_q <= 1'b0;
			if (!meas_enable) begin
				meas_abort_q <= state_q == lsf_pkg::ST_INTEG;
				state_q <= lsf_pkg::ST_IDLE;
				cnt_q <= '0;
			end else if (restart) begin
				// Partial result dropped, no done pulse
				meas_abort_q <= 1'b1;
				meas_start_q <= 1'b1;
				state_q <= lsf_pkg::ST_INTEG;
				cnt_q <= '0;
			end else begin
				unique case (state_q)
					lsf_pkg::ST_IDLE: begin
						meas_start_q <= 1'b1;
						state_q <= lsf_pkg::ST_INTEG;
						cnt_q <= '0;
					end
					lsf_pkg::ST_INTEG: begin
						if (unit_tick) begin
							if (cnt_q + lsf_pkg::CNT_W'(1) >= integ_limit) begin
								meas_done_q <= 1'b1;
								cnt_q <= '0;
								if (wait_scale_q.wait_sel == 4'h0) begin
									meas_start_q <= 1'b1;
								end else begin
									state_q <= lsf_pkg::ST_WAIT;
								end
							end else begin
								cnt_q <= cnt_q + lsf_pkg::CNT_W'(1);
							end
						end
					end
					lsf_pkg::ST_WAIT: begin
						if (slow_tick) begin
							if (cnt_q + lsf_pkg::CNT_W'(1) >= wait_limit) begin
								meas_start_q <= 1'b1;
								state_q <= lsf_pkg::ST_INTEG;
								cnt_q <= '0;
							end else begin
								cnt_q <= cnt_q + lsf_pkg::CNT_W'(1);
							end
						end
					end
					default: begin
						state_q <= lsf_pkg::ST_IDLE;
						cnt_q <= '0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			integrating_q <= 1'b0;
		end else begin
			integrating_q <= state_q == lsf_pkg::ST_INTEG;
		end
	end

endmodule
`default_nettype wire

// >>> verif/lsf_host.sv
// Host model that issues single-byte register accesses to the block
`timescale 1ns/1ps
`default_nettype none
module lsf_host (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output var lsf_pkg::lsf_req_s req
);
	initial req = '0;
	// One-cycle request, answer taken one cycle later
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		req <= {w, !w, a, d};
		@(posedge clk);
		req <= '0;
		#1 q = rdata;
	endtask
endmodule
`default_nettype wire

// >>> verif/lsf_top_chk.sv
// Port-level assertions for the flag and configuration block
`timescale 1ns/1ps
`default_nettype none
module lsf_chk (
	input wire logic clk,
	input wire logic reset,
	input wire lsf_pkg::lsf_req_s req,
	input wire logic [5:0] flag_set,
	input wire logic clear_source_sel,
	input wire logic dark_low_read,
	input wire logic reset_cmd,
	input wire logic sync_single_en,
	input wire logic meas_enable,
	input wire logic [7:0] rdata_q,
	input wire logic [5:0] flags_q,
	input wire logic [8:0] analog_gain_q,
	input wire logic [4:0] digital_gain_q,
	input wire logic dark_sub_en_q,
	input wire logic integrating_q,
	input wire logic meas_start_q,
	input wire logic meas_abort_q
);
	logic fl_rd, ga_wr, ws_wr, clr;
	assign fl_rd = req.rd && req.addr == lsf_pkg::ADDR_FLAGS;
	assign ga_wr = req.wr && req.addr == lsf_pkg::ADDR_GAIN_INT;
	assign ws_wr = req.wr && req.addr == lsf_pkg::ADDR_WAIT_SCALE;
	assign clr = fl_rd && !clear_source_sel || dark_low_read && clear_source_sel;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_flag_set;
		|flag_set |=> (flags_q & $past(flag_set)) == $past(flag_set);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");
	property p_hold;
		!(clr || reset_cmd || sync_single_en)
			|=> (flags_q & $past(flags_q)) == $past(flags_q);
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped");
	property p_clr_rd;
		clr && flag_set == 6'h00 |=> flags_q == 6'h00;
	endproperty
	a_clr_rd: assert property (p_clr_rd) else $error("read no clear");
	property p_clr_cmd;
		(reset_cmd || sync_single_en) && flag_set == 6'h00 |=> flags_q == 6'h00;
	endproperty
	a_clr_cmd: assert property (p_clr_cmd) else $error("cmd no clear");
	property p_rd;
		fl_rd |=> rdata_q == {2'h0, $past(flags_q)};
	endproperty
	a_rd: assert property (p_rd) else $error("flag read data");
	property p_again;
		ga_wr && req.wdata[2] |-> ##3 analog_gain_q == 9'h100;
	endproperty
	a_again: assert property (p_again) else $error("analog gain");
	property p_post_scale_sel;
		ws_wr |-> ##3 dark_sub_en_q == $past(req.wdata[4], 3)
			&& digital_gain_q == ($past(req.wdata[7], 3) ? 5'h10 :
			5'(5'h01 << $past(req.wdata[6:5], 3)));
	endproperty
	a_post_scale_sel: assert property (p_post_scale_sel) else $error("scale cfg");
	property p_restart;
		(ga_wr || ws_wr) && integrating_q && meas_enable
			|=> meas_abort_q && meas_start_q;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
endmodule
bind lsf_top lsf_chk chk (.clk, .reset, .req, .flag_set, .clear_source_sel,
	.dark_low_read, .reset_cmd, .sync_single_en, .meas_enable, .rdata_q,
	.flags_q, .analog_gain_q, .digital_gain_q, .dark_sub_en_q,
	.integrating_q, .meas_start_q, .meas_abort_q);
`default_nettype wire

// >>> verif/lsf_top_tb_top.sv
// Self-checking bench for the flag and configuration block
`timescale 1ns/1ps
`default_nettype none
module lsf_top_tb_top;
	logic clk, reset, clear_source_sel, dark_low_read, reset_cmd;
	logic sync_single_en, meas_enable, dark_sub_en_q, integrating_q;
	logic meas_start_q, meas_done_q, meas_abort_q;
	logic [5:0] flag_set, flags_q;
	logic [7:0] rdata_q, q;
	logic [8:0] analog_gain_q;
	logic [4:0] digital_gain_q;
	lsf_pkg::lsf_req_s req;
	int error_cnt, num_checks, n, mflags, r;
	int ag[8] = '{1, 4, 16, 128, 256, 256, 256, 256};
	localparam int SLOW = lsf_pkg::SLOW_CYCLES;
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	lsf_host host (.clk, .rdata(rdata_q), .req);
	lsf_top dut (.clk, .reset, .req, .flag_set, .clear_source_sel,
		.dark_low_read, .reset_cmd, .sync_single_en, .meas_enable, .rdata_q,
		.flags_q, .analog_gain_q, .digital_gain_q, .dark_sub_en_q,
		.integrating_q, .meas_start_q, .meas_done_q, .meas_abort_q);
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic chk_flags(input logic [5:0] got, input logic [5:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: flags %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host.xfer(0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic fset(input logic [5:0] f);
		@(posedge clk);
		flag_set <= f;
		@(posedge clk);
		flag_set <= 6'h00;
		mflags |= f;
	endtask
	initial begin
		r = $urandom(17453);
		{reset, flag_set, clear_source_sel, dark_low_read} = {1'b1, 8'h00};
		{reset_cmd, sync_single_en, meas_enable} = 3'h0;
		error_cnt = 0;
		num_checks = 0;
		mflags = 0;
		repeat (3) @(posedge clk);
		reset <= 0;
		rd(8'h09, 8'h40);
		rd(8'h0a, 8'h10);
		rd(8'h08, 8'h00);
		rd(8'h1f, 8'h00);
		chk(analog_gain_q, 9'h001);
		chk(digital_gain_q, 9'h001);
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			host.xfer(1, 8'h09, {r[7:3], 3'(i)}, q);
			host.xfer(1, 8'h0a, {3'(i), r[4:0]}, q);
			repeat (3) @(posedge clk);
			#1 chk(analog_gain_q, 9'(ag[i]));
			chk(digital_gain_q, 9'(i > 3 ? 16 : 1 << i));
			chk(dark_sub_en_q, r[4]);
			rd(8'h0a, {3'(i), r[4:0]});
			rd(8'h09, {r[7:3], 3'(i)});
		end
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			clear_source_sel <= s[0];
			r = $urandom;
			fset(r[5:0]);
			rd(8'h08, 8'(mflags));
			if (s == 0)
				mflags = 0;
			chk_flags(flags_q, 6'(mflags));
			fset(6'h24);
			@(posedge clk);
			dark_low_read <= 1;
			@(posedge clk);
			dark_low_read <= 0;
			if (s == 1)
				mflags = 0;
			#1 chk_flags(flags_q, 6'(mflags));
			rd(8'h08, 8'(mflags));
			mflags = 0;
			#1 chk_flags(flags_q, 6'h00);
		end
		for (int k = 0; k < 2; k++) begin
			fset(6'h21);
			@(posedge clk);
			{reset_cmd, sync_single_en} <= {!k[0], k[0]};
			flag_set <= 6'(k * 2);
			@(posedge clk);
			{reset_cmd, sync_single_en} <= 2'h0;
			flag_set <= 6'h00;
			mflags = k * 2;
			#1 chk_flags(flags_q, 6'(mflags));
		end
		host.xfer(1, 8'h09, 8'h00, q);
		host.xfer(1, 8'h0a, 8'h10, q);
		@(posedge clk);
		clear_source_sel <= 0;
		meas_enable <= 1;
		for (n = 0; n < 50 && integrating_q !== 1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(integrating_q, 9'h001);
		if (n == 50)
			end_sim();
		for (int j = 0; j < 2; j++) begin
			host.xfer(1, 8'h09 + 8'(j), j ? 8'h10 : 8'h00, q);
			for (n = 0; n < 4 && meas_abort_q !== 1; n++) begin
				@(posedge clk);
				#1;
			end
			chk(n < 4, 1);
			if (n == 4)
				end_sim();
			for (n = 0; n < 2500 && meas_done_q !== 1; n++) begin
				@(posedge clk);
				#1;
			end
			chk(n >= 1998 && n <= 2002, 1);
			chk(meas_start_q, 1);
			if (n == 2500)
				end_sim();
		end
		host.xfer(1, 8'h0a, 8'h11, q);
		for (n = 0; n < 2500 && meas_done_q !== 1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(n >= 1998 && n <= 2002, 1);
		chk(meas_start_q, 9'h000);
		for (n = 0; n < 8000 && meas_start_q !== 1; n++) begin
			@(posedge clk);
			#1;
		end
		chk((n + SLOW - 1) / SLOW == 128, 1);
		if (n == 8000)
			end_sim();
		@(posedge clk);
		meas_enable <= 0;
		@(posedge clk);
		#1 chk(meas_abort_q, 9'h001);
		end_sim();
	end
endmodule
`default_nettype wire
